// [rtl/acap_capture.v]
// Sample capture: two digitizer links, four signal paths, packed 32-bit words.
// Assumes link clocks and data are asynchronous pins, center-aligned DDR data,
// and a link clock slow enough that the core clock sees every phase.
`timescale 1ns/10ps
`default_nettype none
`include "acap_consts.vh"

module acap_capture (
  input wire core_clk,
  input wire rstn,
  input wire [`ACAP_UNITS-1:0] link_clk,
  input wire [`ACAP_UNITS*`ACAP_LINK_W-1:0] link_data,
  input wire pps,
  output wire [`ACAP_UNITS-1:0] out_valid,
  input wire [`ACAP_UNITS-1:0] out_ready,
  output wire [`ACAP_UNITS*`ACAP_UNIT_DW-1:0] out_data,
  output wire [`ACAP_UNITS-1:0] out_sync,
  output wire [`ACAP_UNITS*`ACAP_BSN_W-1:0] out_bsn,
  output wire [`ACAP_UNITS-1:0] phase_fault,
  output wire [`ACAP_UNITS-1:0] overflow
);

  // Pulse per second: one shared synchroniser so all units see one edge
  reg pps_s1_ff;
  reg pps_s2_ff;
  reg pps_s3_ff;
  wire pps_edge;

  always @(posedge core_clk) begin
    if (!rstn) begin
      pps_s1_ff <= 1'b0;
      pps_s2_ff <= 1'b0;
      pps_s3_ff <= 1'b0;
    end else begin
      pps_s1_ff <= pps;
      pps_s2_ff <= pps_s1_ff;
      pps_s3_ff <= pps_s2_ff;
    end
  end

  assign pps_edge = pps_s2_ff & ~pps_s3_ff;

  genvar u;
  generate
    for (u = 0; u < `ACAP_UNITS; u = u + 1) begin : g_unit
      reg clk_s1_ff;
      reg clk_s2_ff;
      reg clk_s3_ff;
      reg [`ACAP_LINK_W-1:0] dat_s1_ff;
      reg [`ACAP_LINK_W-1:0] dat_s2_ff;
      reg div_ff;
      reg [`ACAP_SLOT_W-1:0] slot_ff;
      reg [`ACAP_WORD_W-1:0] word_a_ff;
      reg [`ACAP_WORD_W-1:0] word_b_ff;
      reg word_done_ff;
      reg sync_pend_ff;
      reg [`ACAP_BSN_W-1:0] bsn_ff;
      reg fault_ff;
      reg ovf_ff;
      reg [`ACAP_SLOT_W-1:0] nxt_slot;
      reg nxt_store;
      reg nxt_fault;
      wire rise;
      wire fall;
      wire any_edge;
      wire in_ready;
      wire [`ACAP_FIFO_W-1:0] fifo_out;
      wire [`ACAP_SMP_W-1:0] smp_a;
      wire [`ACAP_SMP_W-1:0] smp_b;

      // Registered inputs only; a fixed two-flop path keeps the crossing delay constant
      always @(posedge core_clk) begin
        if (!rstn) begin
          clk_s1_ff <= 1'b0;
          clk_s2_ff <= 1'b0;
          clk_s3_ff <= 1'b0;
          dat_s1_ff <= {`ACAP_LINK_W{1'b0}};
          dat_s2_ff <= {`ACAP_LINK_W{1'b0}};
        end else begin
          clk_s1_ff <= link_clk[u];
          clk_s2_ff <= clk_s1_ff;
          clk_s3_ff <= clk_s2_ff;
          dat_s1_ff <= link_data[u*`ACAP_LINK_W +: `ACAP_LINK_W];
          dat_s2_ff <= dat_s1_ff;
        end
      end

      // Both link edges carry a sample
      assign rise = clk_s2_ff & ~clk_s3_ff;
      assign fall = ~clk_s2_ff & clk_s3_ff;
      assign any_edge = rise | fall;
      // Data sampled with the clock change: middle of a center-aligned eye
      assign smp_a = dat_s2_ff[`ACAP_SMP_W-1:0];
      assign smp_b = dat_s2_ff[`ACAP_LINK_W-1:`ACAP_SMP_W];

      // Slot check: even slots on rising edges, slot 0 on a rising edge with div low
      always @* begin
        nxt_slot = slot_ff;
        nxt_store = 1'b0;
        nxt_fault = 1'b0;
        if (any_edge) begin
          if ((rise == ~slot_ff[0]) && (slot_ff[0] || (div_ff == slot_ff[1]))) begin
            nxt_store = 1'b1;
            nxt_slot = slot_ff + `ACAP_SLOT_ONE;
          end else begin
            nxt_fault = 1'b1;
            if (rise && !div_ff) begin
              nxt_store = 1'b1;
              nxt_slot = `ACAP_SLOT_ONE;
            end else begin
              nxt_slot = `ACAP_SLOT_FIRST;
            end
          end
        end
      end

      always @(posedge core_clk) begin
        if (!rstn) begin
          div_ff <= 1'b0;
          slot_ff <= `ACAP_SLOT_FIRST;
          word_a_ff <= {`ACAP_WORD_W{1'b0}};
          word_b_ff <= {`ACAP_WORD_W{1'b0}};
          word_done_ff <= 1'b0;
          fault_ff <= 1'b0;
        end else begin
          if (pps_edge) begin
            // Halving and grouping restart on the same core cycle in every node
            div_ff <= 1'b0;
            slot_ff <= `ACAP_SLOT_FIRST;
          end else begin
            if (rise) begin
              div_ff <= ~div_ff;
            end
            slot_ff <= nxt_slot;
          end
          if (nxt_store && !pps_edge) begin
            // Shift down so the first sample ends in the low byte
            word_a_ff <= {smp_a, word_a_ff[`ACAP_WORD_W-1:`ACAP_SMP_W]};
            word_b_ff <= {smp_b, word_b_ff[`ACAP_WORD_W-1:`ACAP_SMP_W]};
          end
          word_done_ff <= nxt_store && !pps_edge && (slot_ff == `ACAP_SLOT_LAST);
          // Sticky; only reset clears it
          if (nxt_fault && !pps_edge) begin
            fault_ff <= 1'b1;
          end
        end
      end

      // Sequence number and sync mark, one step per word
      always @(posedge core_clk) begin
        if (!rstn) begin
          bsn_ff <= `ACAP_BSN_ZERO;
          sync_pend_ff <= 1'b0;
        end else begin
          // Set wins over the clear, so a pulse that meets a finished word
          // still marks the next one
          if (pps_edge) begin
            sync_pend_ff <= 1'b1;
          end else if (word_done_ff) begin
            sync_pend_ff <= 1'b0;
          end
          if (word_done_ff) begin
            // Dropped words still count, so gaps in the number show the loss
            if (sync_pend_ff) begin
              bsn_ff <= `ACAP_BSN_ZERO;
            end else begin
              bsn_ff <= bsn_ff + `ACAP_BSN_ONE;
            end
          end
        end
      end

      // Overflow: link cannot be stalled, so a refused word is flagged, never hidden
      always @(posedge core_clk) begin
        if (!rstn) begin
          ovf_ff <= 1'b0;
        end else if (word_done_ff && !in_ready) begin
          ovf_ff <= 1'b1;
        end
      end

      wire [`ACAP_BSN_W-1:0] word_bsn;
      assign word_bsn = sync_pend_ff ? `ACAP_BSN_ZERO : (bsn_ff + `ACAP_BSN_ONE);

      acap_fifo #(
        .WIDTH(`ACAP_FIFO_W),
        .DEPTH(`ACAP_FIFO_DEPTH),
        .AW(`ACAP_FIFO_AW)
      ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(word_done_ff),
        .in_ready(in_ready),
        .in_data({sync_pend_ff, word_bsn, word_b_ff, word_a_ff}),
        .out_valid(out_valid[u]),
        .out_ready(out_ready[u]),
        .out_data(fifo_out)
      );

      assign out_data[u*`ACAP_UNIT_DW +: `ACAP_UNIT_DW] = fifo_out[`ACAP_UNIT_DW-1:0];
      assign out_bsn[u*`ACAP_BSN_W +: `ACAP_BSN_W] =
        fifo_out[`ACAP_UNIT_DW+`ACAP_BSN_W-1:`ACAP_UNIT_DW];
      assign out_sync[u] = fifo_out[`ACAP_FIFO_W-1];
      assign phase_fault[u] = fault_ff;
      assign overflow[u] = ovf_ff;
    end
  endgenerate

endmodule // acap_capture

`default_nettype wire

// [rtl/acap_consts.vh]
// Constants for the sample capture block: widths, counts, depths.
// Included by the capture design file only, not by the FIFO; holds definitions only.
`ifndef ACAP_CONSTS_VH
`define ACAP_CONSTS_VH

`define ACAP_SMP_W 8
`define ACAP_UNITS 2
`define ACAP_PATHS_PER_UNIT 2
`define ACAP_LINK_W 16
`define ACAP_WORD_W 32
`define ACAP_UNIT_DW 64
`define ACAP_SLOT_W 2
`define ACAP_SLOT_FIRST 2'h0
`define ACAP_SLOT_ONE 2'h1
`define ACAP_SLOT_LAST 2'h3
`define ACAP_BSN_W 16
`define ACAP_BSN_ZERO 16'h0000
`define ACAP_BSN_ONE 16'h0001
`define ACAP_FIFO_W 81
`define ACAP_FIFO_DEPTH 4
`define ACAP_FIFO_AW 2

`endif

// [rtl/acap_fifo.v]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module acap_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign in_ready = ({{(31-AW){1'b0}}, count_ff} != DEPTH);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Read straight from the storage flops, no extra latency
  assign out_data = mem_ff[rd_ptr_ff];

  always @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // acap_fifo

`default_nettype wire

// [sim/acap_adc_model.sv]
// Two converter units: ramp samples on both link clock edges.
// Assumes run changes between groups; clock idles low when stopped.
`timescale 1ns/10ps
`default_nettype none
module acap_adc_model (
  input wire logic run,
  output var logic [1:0] link_clk,
  output var logic [31:0] link_data
);
  logic [7:0] k;
  initial begin
    link_clk = 2'h0;
    link_data = 32'h0;
    k = 8'h00;
    forever begin
      wait (run === 1'b1);
      k = 8'h00;
      // Whole groups only, so a stop never leaves half a word behind
      while (run === 1'b1) begin
        repeat (4) begin
          link_data = {k + 8'hC0, k + 8'h80, k + 8'h40, k};
          #20 link_clk = ~link_clk;
          #20 k = k + 8'h01;
        end
      end
      link_data = ~link_data;
    end
  end
endmodule // acap_adc_model
`default_nettype wire

// [sim/acap_capture_asserts.sv]
// Port checker for the capture block.
// Assumes binding into acap_capture; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module acap_capture_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] link_clk,
  input wire logic [31:0] link_data,
  input wire logic pps,
  input wire logic [1:0] out_valid,
  input wire logic [1:0] out_ready,
  input wire logic [127:0] out_data,
  input wire logic [1:0] out_sync,
  input wire logic [31:0] out_bsn,
  input wire logic [1:0] phase_fault,
  input wire logic [1:0] overflow
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] last_bsn_ff;
  logic have_bsn_ff;
  logic pps_seen_ff;
  always @(posedge core_clk) begin
    if (!rstn) begin
      have_bsn_ff <= 1'b0;
      pps_seen_ff <= 1'b0;
      last_bsn_ff <= 16'h0000;
    end else begin
      pps_seen_ff <= pps_seen_ff | pps;
      if (out_valid[0] && out_ready[0]) begin
        have_bsn_ff <= 1'b1;
        last_bsn_ff <= out_bsn[15:0];
      end
    end
  end
  property p_rst_clear; $rose(rstn) |-> {out_valid, phase_fault, overflow} == 6'h00; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("flags not clear after reset");
  property p_fault_keep; phase_fault != 2'h0 |=> (phase_fault & $past(phase_fault)) == $past(phase_fault); endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("phase fault dropped");
  property p_ovf_keep; overflow != 2'h0 |=> (overflow & $past(overflow)) == $past(overflow); endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow dropped");
  property p_hold0; out_valid[0] && !out_ready[0] |=> out_valid[0] && $stable(out_data[63:0]); endproperty
  a_hold0: assert property (p_hold0) else $error("unit 0 word changed while stalled");
  property p_hold1; out_valid[1] && !out_ready[1] |=> out_valid[1] && $stable(out_data[127:64]); endproperty
  a_hold1: assert property (p_hold1) else $error("unit 1 word changed while stalled");
  property p_sync0; out_valid[0] && out_sync[0] |-> out_bsn[15:0] == 16'h0000; endproperty
  a_sync0: assert property (p_sync0) else $error("unit 0 sync word count not zero");
  property p_sync1; out_valid[1] && out_sync[1] |-> out_bsn[31:16] == 16'h0000; endproperty
  a_sync1: assert property (p_sync1) else $error("unit 1 sync word count not zero");
  property p_bsn_step; out_valid[0] && out_ready[0] && !out_sync[0] && have_bsn_ff && !overflow[0]
    |-> out_bsn[15:0] == last_bsn_ff + 16'h0001; endproperty
  a_bsn_step: assert property (p_bsn_step) else $error("sequence number skipped");
  property p_sync_pps; out_valid[1] && out_sync[1] |-> pps_seen_ff; endproperty
  a_sync_pps: assert property (p_sync_pps) else $error("sync word without pulse");
endmodule // acap_capture_asserts
`default_nettype wire

// [sim/tb_adc_sample_capture.sv]
// Bench for the capture block: converter model, stream, stall, reset.
// Assumes the design files and their header on the include path.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_sample_capture;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic pps = 1'b0;
  logic run = 1'b0;
  logic [1:0] out_ready = 2'h0;
  wire [1:0] link_clk;
  wire [31:0] link_data;
  wire [1:0] out_valid;
  wire [127:0] out_data;
  wire [1:0] out_sync;
  wire [31:0] out_bsn;
  wire [1:0] phase_fault;
  wire [1:0] overflow;
  int fail_count = 0;
  int cmp_count = 0;
  always #2 core_clk = ~core_clk;
  acap_adc_model acap_adc_model_i (.run(run), .link_clk(link_clk), .link_data(link_data));
  acap_capture acap_capture_i (.core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
    .link_data(link_data), .pps(pps), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_sync(out_sync), .out_bsn(out_bsn),
    .phase_fault(phase_fault), .overflow(overflow));
  task test_done;
    $display("mismatches %0d of %0d compares", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  function automatic logic [31:0] grp(input logic [7:0] b);
    grp = {b + 8'h03, b + 8'h02, b + 8'h01, b};
  endfunction
  task pop(input int u, input logic [7:0] k, input logic [15:0] block_sequence_number, input logic sync);
    int n;
    logic [7:0] b;
    n = 0;
    b = k + (u == 1 ? 8'h80 : 8'h00);
    do begin
      @(negedge core_clk);
      n++;
    end while (out_valid[u] !== 1'b1 && n < 400);
    if (out_valid[u] !== 1'b1) begin
      fail_count++;
      test_done();
    end
    chk(out_data[u*64+:64], {grp(b + 8'h40), grp(b)});
    chk({out_bsn[u*16+:16], 47'h0, out_sync[u]}, {block_sequence_number, 47'h0, sync});
    out_ready[u] = 1'b1;
    @(negedge core_clk);
    out_ready[u] = 1'b0;
  endtask
  task pulse_pps;
    pps = 1'b1;
    repeat (10) @(negedge core_clk);
    pps = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask
  task t_stream;
    pulse_pps();
    run = 1'b1;
    for (int w = 0; w < 3; w++) begin
      pop(0, 8'(4 * w), 16'(w), w == 0);
      pop(1, 8'(4 * w), 16'(w), w == 0);
    end
    run = 1'b0;
    chk({60'h0, phase_fault, overflow}, 64'h0);
    repeat (100) @(negedge core_clk);
    // Drain what the last group left behind
    out_ready = 2'h3;
    repeat (20) @(negedge core_clk);
    out_ready = 2'h0;
  endtask
  task t_stall;
    int n;
    n = 0;
    pulse_pps();
    run = 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (overflow !== 2'h3 && n < 600);
    run = 1'b0;
    chk({62'h0, overflow}, 64'h3);
    if (overflow !== 2'h3)
      test_done();
    repeat (100) @(negedge core_clk);
    for (int w = 0; w < 4; w++)
      pop(0, 8'(4 * w), 16'(w), w == 0);
    for (int w = 0; w < 4; w++)
      pop(1, 8'(4 * w), 16'(w), w == 0);
    @(negedge core_clk);
    chk({62'h0, out_valid}, 64'h0);
  endtask
  task t_slip;
    chk({62'h0, phase_fault}, 64'h0);
    run = 1'b1;
    repeat (10) @(negedge core_clk);
    // Pulse lands one sample into a group, so the next fall meets slot 0 and flags a phase fault
    pps = 1'b1;
    repeat (10) @(negedge core_clk);
    pps = 1'b0;
    run = 1'b0;
    repeat (20) @(negedge core_clk);
    chk({62'h0, phase_fault}, 64'h3);
  endtask
  task t_reset;
    run = 1'b1;
    repeat (300) @(negedge core_clk);
    rstn = 1'b0;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    run = 1'b0;
    chk({58'h0, out_valid, overflow, phase_fault}, 64'h0);
    repeat (100) @(negedge core_clk);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    t_stream();
    t_stall();
    t_slip();
    t_reset();
    test_done();
  end
endmodule // tb_adc_sample_capture
bind acap_capture acap_capture_asserts acap_capture_asserts_i (.core_clk(core_clk),
  .rstn(rstn), .link_clk(link_clk), .link_data(link_data), .pps(pps),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sync(out_sync),
  .out_bsn(out_bsn), .phase_fault(phase_fault), .overflow(overflow));
`default_nettype wire
